/* File: hw/cpu_core_regs_defs.vh */
// constants for the cpu core register set and flag logic
`ifndef CPU_CORE_REGS_DEFS_VH
`define CPU_CORE_REGS_DEFS_VH

// ************************************************************
// register byte offsets on the axi4-lite slave
// ************************************************************
`define OFS_PROG_COUNTER 8'h00
`define OFS_ACCUM 8'h04
`define OFS_TMP_ACCUM 8'h08
`define OFS_INDEX_REG 8'h0C
`define OFS_EXTRA_POINTER 8'h10
`define OFS_STACK_PTR 8'h14
`define OFS_PROG_STATUS_WORD 8'h18
`define OFS_ALU_CMD 8'h1C
`define OFS_BANK_ADDR 8'h20
`define OFS_CORE_STATUS 8'h24

// ************************************************************
// field positions in cond_flags (low byte of status word)
// ************************************************************
`define FLG_HALF 7
`define FLG_IRQ_EN 6
`define FLG_IRQ_LEVEL_HI 5
`define FLG_IRQ_LEVEL_LO 4
`define FLG_NEG 3
`define FLG_ZERO 2
`define FLG_OVF 1
`define FLG_CARRY 0

// ************************************************************
// alu command field: bit 4 word mode, bits 3:0 operation
// ************************************************************
`define ALU_WORD_BIT 4
`define OP_ADD 4'h0
`define OP_ADDC 4'h1
`define OP_SUB 4'h2
`define OP_SUBC 4'h3
`define OP_SHL 4'h4
`define OP_SHR 4'h5
`define OP_AND 4'h6
`define OP_OR 4'h7
`define OP_XOR 4'h8
`define OP_CMP 4'h9

// ************************************************************
// reset values and memory map figures
// ************************************************************
`define RST_REG16 16'h0000
`define RST_STATUS_WORD 16'h0030
`define BANK_BASE_ADDR 16'h0100
`define BANK_REGS_LOG2 3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define REGION_IO 2'b00
`define REGION_DATA 2'b01
`define REGION_PROG 2'b10

`endif

/* File: hw/cpu_core_regs_and_flags.v */
// dedicated cpu registers, status word and condition flag logic behind axi4-lite
//
// Functional notes
// - program counter is a 16-bit register
// - 16-bit accumulator, low byte in byte ops
// - 16-bit second operand, low byte in byte ops
// - index register is 16 bits wide
// - extra pointer is a 16-bit address
// - stack pointer is a 16-bit register
// - status word: bank pointer high, flags low
// - half-carry on carry/borrow bit 3 to 4
// - interrupt enable gates requests, reset clears it
// - two-bit level field masks lower-priority requests
// - negative flag copies result msb
// - zero flag set on zero result
// - overflow flag on two's-complement overflow
// - carry flag on carry/borrow out of bit 7; word ops take it out of bit 15
// - shifts load carry with shifted-out bit
// - eight byte registers per bank, pointer-selected
// - banks from 0100h, 16 or 32 banks
// - 64-Kbyte space: io low, data, program high
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_core_regs_defs.vh"

module cpu_core_regs_and_flags #(
	parameter LARGE_RAM = 1,
	parameter [15:0] IO_TOP = 16'h007F,
	parameter [15:0] PROG_BASE = 16'h4000
) (
	input wire ref_clk_i, // 200 MHz core clock
	input wire reset_n_i, // async reset, active low
	input wire [7:0] s_axi_awaddr_i, // write address
	input wire s_axi_awvalid_i, // write address valid
	output wire s_axi_awready_o, // write address ready
	input wire [31:0] s_axi_wdata_i, // write data
	input wire [3:0] s_axi_wstrb_i, // write byte strobes
	input wire s_axi_wvalid_i, // write data valid
	output wire s_axi_wready_o, // write data ready
	output reg [1:0] s_axi_bresp_o, // write response
	output reg s_axi_bvalid_o, // write response valid
	input wire s_axi_bready_i, // write response ready
	input wire [7:0] s_axi_araddr_i, // read address
	input wire s_axi_arvalid_i, // read address valid
	output wire s_axi_arready_o, // read address ready
	output reg [31:0] s_axi_rdata_o, // read data
	output reg [1:0] s_axi_rresp_o, // read response
	output reg s_axi_rvalid_o, // read data valid
	input wire s_axi_rready_i, // read data ready
	input wire irq_req_i, // interrupt request pin, async
	input wire [1:0] irq_req_level_i, // level code of the request, async
	output reg irq_accept_o, // request passes enable and level mask
	output reg [15:0] bank_addr_o // byte address of current bank
);

	// ************************************************************
	// functions
	// ************************************************************

	// merge a 16-bit register with strobed bus data
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
			merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
		end
	endfunction

	// priority number of a level code, smaller is more urgent
	function [1:0] level_of;
		input [1:0] code;
		begin
			case (code)
				2'b00: level_of = 2'd1;
				2'b01: level_of = 2'd1;
				2'b10: level_of = 2'd2;
				default: level_of = 2'd3;
			endcase
		end
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	localparam [5:0] BANK_MASK = LARGE_RAM ? 6'h1F : 6'h0F;
	localparam [15:0] RST_SW = `RST_STATUS_WORD; // split into pointer and flag halves
	reg [15:0] prog_counter_q;
	reg [15:0] accum_q;
	reg [15:0] tmp_accum_q;
	reg [15:0] index_reg_q;
	reg [15:0] extra_pointer_q;
	reg [15:0] stack_ptr_q;
	reg [7:0] bank_select_pointer_q;
	reg [7:0] cond_flags_q;
	reg [4:0] alu_cmd_q;
	reg aw_full_q;
	reg w_full_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [2:0] irq_sync1_q;
	reg [2:0] irq_sync2_q;
	wire do_write;
	wire do_read;
	wire alu_go;
	wire word_mode;
	wire [3:0] alu_op;
	wire [7:0] cond_flags_wr;
	wire bank_in_range;
	reg [1:0] ep_region;

	// ************************************************************
	// axi4-lite handshakes
	// ************************************************************

	// address and data are buffered separately, taken in either order
	assign s_axi_awready_o = ~aw_full_q;
	assign s_axi_wready_o = ~w_full_q;
	assign s_axi_arready_o = ~s_axi_rvalid_o;
	assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid_o;
	assign do_read = s_axi_arvalid_i & ~s_axi_rvalid_o;
	assign alu_go = do_write & (aw_addr_q == `OFS_ALU_CMD) & w_strb_q[0];
	assign word_mode = w_data_q[`ALU_WORD_BIT];
	assign alu_op = w_data_q[3:0];

	// write channel capture and response
	always @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid_i && !aw_full_q)
			begin
				aw_full_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr_i[7:2], 2'b00};
			end
			if (s_axi_wvalid_i && !w_full_q)
			begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
			end
			if (do_write)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				case (aw_addr_q)
					`OFS_PROG_COUNTER, `OFS_ACCUM, `OFS_TMP_ACCUM, `OFS_INDEX_REG,
					`OFS_EXTRA_POINTER, `OFS_STACK_PTR, `OFS_PROG_STATUS_WORD,
					`OFS_ALU_CMD: s_axi_bresp_o <= `RESP_OKAY;
					default: s_axi_bresp_o <= `RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid_o && s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
		end
	end

	// ************************************************************
	// alu and flag generation
	// ************************************************************
	reg [15:0] op_a;
	reg [15:0] op_b;
	reg [16:0] wide;
	reg [4:0] nib;
	reg [15:0] res;
	reg sub_op;
	reg cy_in;
	reg sa;
	reg sb;
	reg sr;
	reg [7:0] flags_alu;
	reg [15:0] accum_alu;

	// byte ops see only the low bytes of both operands
	always @*
	begin
		op_a = word_mode ? accum_q : {8'h00, accum_q[7:0]};
		op_b = word_mode ? tmp_accum_q : {8'h00, tmp_accum_q[7:0]};
		sub_op = (alu_op == `OP_SUB) | (alu_op == `OP_SUBC) | (alu_op == `OP_CMP);
		cy_in = ((alu_op == `OP_ADDC) | (alu_op == `OP_SUBC)) & cond_flags_q[`FLG_CARRY];
		if (sub_op)
		begin
			wide = {1'b0, op_a} - {1'b0, op_b} - {16'h0000, cy_in};
			nib = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, cy_in};
		end
		else
		begin
			wide = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, cy_in};
			nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cy_in};
		end
		flags_alu = cond_flags_q;
		case (alu_op)
			`OP_ADD, `OP_ADDC, `OP_SUB, `OP_SUBC, `OP_CMP:
			begin
				res = wide[15:0];
				flags_alu[`FLG_HALF] = nib[4];
				flags_alu[`FLG_CARRY] = word_mode ? wide[16] : wide[8];
			end
			`OP_SHL:
			begin
				res = {op_a[14:0], cond_flags_q[`FLG_CARRY]};
				flags_alu[`FLG_CARRY] = word_mode ? op_a[15] : op_a[7];
			end
			`OP_SHR:
			begin
				res = word_mode ? {cond_flags_q[`FLG_CARRY], op_a[15:1]} :
					{8'h00, cond_flags_q[`FLG_CARRY], op_a[7:1]};
				flags_alu[`FLG_CARRY] = op_a[0];
			end
			`OP_AND: res = op_a & op_b;
			`OP_OR: res = op_a | op_b;
			`OP_XOR: res = op_a ^ op_b;
			default: res = op_a;
		endcase
		sa = word_mode ? op_a[15] : op_a[7];
		sb = word_mode ? op_b[15] : op_b[7];
		sr = word_mode ? res[15] : res[7];
		flags_alu[`FLG_NEG] = sr;
		flags_alu[`FLG_ZERO] = word_mode ? (res == 16'h0000) : (res[7:0] == 8'h00);
		if (alu_op == `OP_ADD || alu_op == `OP_ADDC)
			flags_alu[`FLG_OVF] = (sa == sb) & (sr != sa);
		else if (sub_op)
			flags_alu[`FLG_OVF] = (sa != sb) & (sr != sa);
		else
			flags_alu[`FLG_OVF] = 1'b0;
		if (alu_op == `OP_CMP)
			accum_alu = accum_q;
		else if (word_mode)
			accum_alu = res;
		else
			accum_alu = {accum_q[15:8], res[7:0]};
	end

	// ************************************************************
	// dedicated register file
	// ************************************************************
	assign cond_flags_wr = w_strb_q[0] ? w_data_q[7:0] : cond_flags_q;

	// software writes and alu results
	always @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			prog_counter_q <= `RST_REG16;
			accum_q <= `RST_REG16;
			tmp_accum_q <= `RST_REG16;
			index_reg_q <= `RST_REG16;
			extra_pointer_q <= `RST_REG16;
			stack_ptr_q <= `RST_REG16;
			bank_select_pointer_q <= RST_SW[15:8];
			cond_flags_q <= RST_SW[7:0];
			alu_cmd_q <= 5'h00;
		end
		else if (do_write)
		begin
			case (aw_addr_q)
				`OFS_PROG_COUNTER: prog_counter_q <= merge16(prog_counter_q, w_data_q, w_strb_q);
				`OFS_ACCUM: accum_q <= merge16(accum_q, w_data_q, w_strb_q);
				`OFS_TMP_ACCUM: tmp_accum_q <= merge16(tmp_accum_q, w_data_q, w_strb_q);
				`OFS_INDEX_REG: index_reg_q <= merge16(index_reg_q, w_data_q, w_strb_q);
				`OFS_EXTRA_POINTER: extra_pointer_q <= merge16(extra_pointer_q, w_data_q, w_strb_q);
				`OFS_STACK_PTR: stack_ptr_q <= merge16(stack_ptr_q, w_data_q, w_strb_q);
				`OFS_PROG_STATUS_WORD:
				begin
					cond_flags_q <= cond_flags_wr;
					if (w_strb_q[1])
						bank_select_pointer_q <= w_data_q[15:8];
				end
				`OFS_ALU_CMD:
				begin
					if (alu_go)
					begin
						alu_cmd_q <= w_data_q[4:0];
						accum_q <= accum_alu;
						cond_flags_q <= flags_alu;
					end
				end
				default: alu_cmd_q <= alu_cmd_q;
			endcase
		end
	end

	// ************************************************************
	// register banks and memory regions
	// ************************************************************

	// eight byte registers per bank, base 0100h plus 8n
	assign bank_in_range = ({1'b0, bank_select_pointer_q[4:0]} & BANK_MASK)
		== {1'b0, bank_select_pointer_q[4:0]} && bank_select_pointer_q[7:5] == 3'b000;

	// registered byte address of the current bank, base plus eight times the pointer
	always @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			bank_addr_o <= `BANK_BASE_ADDR;
		else
			bank_addr_o <= `BANK_BASE_ADDR
				+ ({8'h00, bank_select_pointer_q} << `BANK_REGS_LOG2);
	end

	// 64-Kbyte map: io lowest, data above, program toward the top
	always @*
	begin
		if (extra_pointer_q <= IO_TOP)
			ep_region = `REGION_IO;
		else if (extra_pointer_q < PROG_BASE)
			ep_region = `REGION_DATA;
		else
			ep_region = `REGION_PROG;
	end

	// ************************************************************
	// interrupt gating
	// ************************************************************

	// two-flop synchroniser for request and its level
	always @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			irq_sync1_q <= 3'b000;
			irq_sync2_q <= 3'b000;
			irq_accept_o <= 1'b0;
		end
		else
		begin
			irq_sync1_q <= {irq_req_i, irq_req_level_i};
			irq_sync2_q <= irq_sync1_q;
			irq_accept_o <= irq_sync2_q[2] & cond_flags_q[`FLG_IRQ_EN]
				& (level_of(irq_sync2_q[1:0]) < level_of({cond_flags_q[`FLG_IRQ_LEVEL_HI],
				cond_flags_q[`FLG_IRQ_LEVEL_LO]}));
		end
	end

	// ************************************************************
	// read channel
	// ************************************************************

	// registered read data, one cycle after the address is taken
	always @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= `RESP_OKAY;
		end
		else if (do_read)
		begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= `RESP_OKAY;
			case ({s_axi_araddr_i[7:2], 2'b00})
				`OFS_PROG_COUNTER: s_axi_rdata_o <= {16'h0000, prog_counter_q};
				`OFS_ACCUM: s_axi_rdata_o <= {16'h0000, accum_q};
				`OFS_TMP_ACCUM: s_axi_rdata_o <= {16'h0000, tmp_accum_q};
				`OFS_INDEX_REG: s_axi_rdata_o <= {16'h0000, index_reg_q};
				`OFS_EXTRA_POINTER: s_axi_rdata_o <= {16'h0000, extra_pointer_q};
				`OFS_STACK_PTR: s_axi_rdata_o <= {16'h0000, stack_ptr_q};
				`OFS_PROG_STATUS_WORD: s_axi_rdata_o <= {16'h0000, bank_select_pointer_q, cond_flags_q};
				`OFS_ALU_CMD: s_axi_rdata_o <= {27'h0000000, alu_cmd_q};
				`OFS_BANK_ADDR: s_axi_rdata_o <= {16'h0000, bank_addr_o};
				`OFS_CORE_STATUS: s_axi_rdata_o <= {28'h0000000, ep_region, irq_accept_o, bank_in_range};
				default:
				begin
					s_axi_rdata_o <= 32'h00000000;
					s_axi_rresp_o <= `RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid_o && s_axi_rready_i)
			s_axi_rvalid_o <= 1'b0;
	end

endmodule // cpu_core_regs_and_flags

`default_nettype wire

/* File: verif/cpu_core_regs_checker.sv */
// assertion checker for bus answers, bank address and interrupt gating
`timescale 1ns/1ps
`default_nettype none
module cpu_core_regs_checker (
	input wire logic ref_clk_i, // clock
	input wire logic reset_n_i, // reset, active low
	input wire logic s_axi_awvalid_i, // aw valid
	input wire logic s_axi_awready_o, // aw ready
	input wire logic s_axi_wvalid_i, // w valid
	input wire logic s_axi_wready_o, // w ready
	input wire logic s_axi_bvalid_o, // b valid
	input wire logic s_axi_arvalid_i, // ar valid
	input wire logic s_axi_arready_o, // ar ready
	input wire logic [7:0] s_axi_araddr_i, // read address
	input wire logic s_axi_rvalid_o, // r valid
	input wire logic [31:0] s_axi_rdata_o, // read data
	input wire logic [1:0] s_axi_rresp_o, // read response
	input wire logic irq_req_i, // request
	input wire logic [1:0] irq_req_level_i, // request level
	input wire logic irq_accept_o, // accepted
	input wire logic [15:0] bank_addr_o // bank address
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	a_bank_grid: assert property (bank_addr_o[2:0] == 3'h0 && bank_addr_o >= 16'h0100 && bank_addr_o <= 16'h08F8)
		else $error("bank address off grid");
	a_bank_reset: assert property ($rose(reset_n_i) |-> bank_addr_o == 16'h0100)
		else $error("bank address not at base after reset");
	a_irq_reset_off: assert property ($rose(reset_n_i) |-> !irq_accept_o [*3])
		else $error("request accepted right after reset");
	a_irq_level_mask: assert property (irq_accept_o |-> ($past(irq_req_i, 3) || $past(irq_req_i, 4))
		&& ($past(irq_req_level_i, 3) != 2'h3 || $past(irq_req_level_i, 4) != 2'h3))
		else $error("accept without an admissible request");
	a_read_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_read_unmapped: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i >= 8'h28
		|=> s_axi_rresp_o == 2'h2)
		else $error("unmapped read not refused");
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o && !s_axi_bvalid_o |-> ##[1:2] s_axi_bvalid_o)
		else $error("write answer late");
endmodule // cpu_core_regs_checker
`default_nettype wire

/* File: verif/cpu_core_regs_and_flags_tb_top.sv */
// self-checking bench for the cpu register set and flag logic
`timescale 1ns/1ps
`default_nettype none
module cpu_core_regs_and_flags_tb_top;
	logic ref_clk_i = 1'b0, reset_n_i = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h00000000, rd;
	logic [3:0] ws = 4'h0;
	logic irq_req = 1'b0;
	logic [1:0] irq_lvl = 2'h0, rs;
	wire awr, wr, bv, arr, rv, acc;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] bank;
	int n_fail = 0, cmp_count = 0, cyc = 0;
	int m[0:9];
	cpu_core_regs_and_flags i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rr), .irq_req_i(irq_req), .irq_req_level_i(irq_lvl), .irq_accept_o(acc),
		.bank_addr_o(bank));
	// ************************************************************
	// clock, watchdog, compare and bus tasks
	// ************************************************************
	always #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		awa <= a;
		wd <= d;
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		do
		begin
			@(posedge ref_clk_i);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
		end while (!bv);
		rs = bresp;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		ara <= a;
		arv <= 1'b1;
		do
		begin
			@(posedge ref_clk_i);
			if (arv && arr) arv <= 1'b0;
		end while (!rv);
		rd = rdata;
		rs = rresp;
	endtask
	// ************************************************************
	// reference model
	// ************************************************************
	function automatic logic acc_exp();
		int q, l;
		q = irq_lvl < 2 ? 1 : irq_lvl;
		l = m[6][5:4] < 2 ? 1 : m[6][5:4];
		return irq_req && m[6][6] && q < l;
	endfunction
	function automatic logic [31:0] exp_rd(input int i);
		int bp, ep;
		bp = m[6] >> 8;
		ep = m[4];
		if (i == 8) return 32'h00000100 + 8 * bp;
		if (i == 9) return {ep <= 16'h007F ? 2'h0 : ep < 16'h4000 ? 2'h1 : 2'h2, acc_exp(), bp < 32};
		return m[i];
	endfunction
	task automatic alu(input logic [4:0] c);
		int a, t, k, sb, r, ci, h, cy, v, b;
		sb = c[4] ? 15 : 7;
		k = (2 << sb) - 1;
		a = m[1] & k;
		t = m[2] & k;
		ci = m[6] & 1;
		h = m[6] >> 7 & 1;
		cy = ci;
		v = 0;
		b = (c[3:0] == 1 || c[3:0] == 3) ? ci : 0;
		case (c[3:0])
			0, 1:
			begin
				r = a + t + b;
				h = ((a & 15) + (t & 15) + b) >> 4;
				cy = r >> (sb + 1) & 1;
				v = (~(a ^ t) & (a ^ r)) >> sb & 1;
			end
			4:
			begin
				r = a << 1 | ci;
				cy = a >> sb & 1;
			end
			5:
			begin
				r = a >> 1 | ci << sb;
				cy = a & 1;
			end
			6: r = a & t;
			7: r = a | t;
			8: r = a ^ t;
			2, 3, 9:
			begin
				r = a - t - b;
				h = (a & 15) < (t & 15) + b;
				cy = a < t + b;
				v = ((a ^ t) & (a ^ r)) >> sb & 1;
			end
			default: r = a;
		endcase
		r = r & k;
		if (c[3:0] != 9) m[1] = m[1] & ~k | r;
		m[6] = m[6] & 16'hFF70 | h << 7 | (r >> sb & 1) << 3 | (r == 0) << 2 | v << 1 | cy;
		m[7] = c;
	endtask
	task automatic wr_reg(input int i, input logic [31:0] d, input logic [3:0] s);
		axi_wr(8'(i * 4), d, s);
		chk(rs, i > 7 ? 2'h2 : 2'h0);
		if (i == 7) alu(d[4:0]);
		if (i < 7) m[i] = {s[1] ? d[15:8] : 8'(m[i] >> 8), s[0] ? d[7:0] : 8'(m[i])};
	endtask
	task automatic rd_reg(input int i);
		axi_rd(8'(i * 4));
		chk(rs, i > 9 ? 2'h2 : 2'h0);
		if (i < 10) chk(rd, exp_rd(i));
	endtask
	// ************************************************************
	// test sequence
	// ************************************************************
	initial
	begin
		int bp[6] = '{0, 15, 16, 31, 32, 255};
		int ep[6] = '{0, 16'h007F, 16'h0080, 16'h3FFF, 16'h4000, 16'hFFFF};
		void'($urandom(41951));
		m = '{0, 0, 0, 0, 0, 0, 16'h0030, 0, 0, 0};
		repeat (8) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		br <= 1'b1;
		rr <= 1'b1;
		for (int i = 0; i < 11; i++) rd_reg(i);
		chk(bank, 32'h00000100);
		$display("test reset values done");
		for (int i = 0; i < 12; i++) if (i < 6 || i > 7)
		begin
			wr_reg(i, $urandom, $urandom);
			rd_reg(i);
		end
		$display("test register access done");
		for (int op = 0; op < 32; op++) for (int n = 0; n < 3; n++)
		begin
			wr_reg(6, $urandom, 4'h3);
			wr_reg(1, n == 0 ? 32'h000080FF : $urandom, 4'h3);
			wr_reg(2, n == 0 ? 32'h00000001 : $urandom, 4'h3);
			wr_reg(7, 5'(op), 4'h1);
			rd_reg(1);
			rd_reg(6);
			rd_reg(7);
		end
		$display("test alu flags done");
		for (int i = 0; i < 6; i++)
		begin
			wr_reg(6, bp[i] << 8, 4'h3);
			wr_reg(4, ep[i], 4'h3);
			rd_reg(8);
			rd_reg(9);
			chk(bank, exp_rd(8));
		end
		$display("test bank and region done");
		for (int k = 0; k < 32; k++)
		begin
			irq_req <= ($urandom % 4) != 0;
			irq_lvl <= k[1:0];
			wr_reg(6, {k[4], k[3:2], 4'h0}, 4'h1);
			repeat (6) @(posedge ref_clk_i);
			chk(acc, acc_exp());
			rd_reg(9);
		end
		$display("test interrupt gating done");
		reset_n_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		m = '{0, 0, 0, 0, 0, 0, 16'h0030, 0, 0, 0};
		rd_reg(6);
		rd_reg(8);
		$display("test second reset done");
		end_sim();
	end
endmodule // cpu_core_regs_and_flags_tb_top
bind cpu_core_regs_and_flags cpu_core_regs_checker i_chk (.ref_clk_i(ref_clk_i),
	.reset_n_i(reset_n_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rresp_o(s_axi_rresp_o), .irq_req_i(irq_req_i), .irq_req_level_i(irq_req_level_i),
	.irq_accept_o(irq_accept_o), .bank_addr_o(bank_addr_o));
`default_nettype wire
